// ===== src/adc_cfg_pkg.sv
// constants, types and decoders of the converter setup register bank
// assumes 32-bit apb data, one aligned word for each 16-bit register
package adc_cfg_pkg;

  localparam int unsigned REG_W = 16;
  localparam int unsigned NUM_REGS = 8;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_GLOBAL_CONFIG = 6'h06;
  localparam logic [5:0] IDX_THRESHOLD_HIGH = 6'h07;
  localparam logic [5:0] IDX_THRESHOLD_LOW = 6'h08;
  localparam logic [5:0] IDX_CHAN0_SETUP = 6'h09;
  localparam logic [5:0] IDX_OFFSET_HIGH = 6'h0a;
  localparam logic [5:0] IDX_OFFSET_LOW = 6'h0b;
  localparam logic [5:0] IDX_GAIN_HIGH = 6'h0c;
  localparam logic [5:0] IDX_GAIN_LOW = 6'h0d;

  // field positions
  localparam int MODE_BIT = 0;
  localparam int LEN_LSB = 1;
  localparam int LEN_MSB = 3;
  localparam int DCF_MSB = 3;
  localparam int LOWER_LSB = 8;
  localparam int SEL_MSB = 1;
  localparam int BYPASS_BIT = 2;
  localparam int PHASE_LSB = 6;

  // writable bits; every other bit is reserved and reads zero
  localparam logic [15:0] MASK_CONFIG = 16'h000f;
  localparam logic [15:0] MASK_FULL = 16'hffff;
  localparam logic [15:0] MASK_THR_LOW = 16'hff0f;
  localparam logic [15:0] MASK_SETUP = 16'hffc7;
  localparam logic [15:0] MASK_UPPER_BYTE = 16'hff00;

  // reset values
  localparam logic [15:0] RESET_ZERO = 16'h0000;
  localparam logic [15:0] RESET_GAIN_HIGH = 16'h8000;

  localparam logic [15:0] REG_MASK [NUM_REGS] = '{MASK_CONFIG, MASK_FULL,
    MASK_THR_LOW, MASK_SETUP, MASK_FULL, MASK_UPPER_BYTE, MASK_FULL,
    MASK_UPPER_BYTE};
  localparam logic [15:0] REG_RESET [NUM_REGS] = '{RESET_ZERO, RESET_ZERO,
    RESET_ZERO, RESET_ZERO, RESET_ZERO, RESET_ZERO, RESET_GAIN_HIGH,
    RESET_ZERO};

  // measurement lengths in conversion periods
  localparam logic [11:0] PERIODS_0 = 12'h080;
  localparam logic [11:0] PERIODS_1 = 12'h100;
  localparam logic [11:0] PERIODS_2 = 12'h200;
  localparam logic [11:0] PERIODS_3 = 12'h300;
  localparam logic [11:0] PERIODS_4 = 12'h500;
  localparam logic [11:0] PERIODS_5 = 12'h700;
  localparam logic [11:0] PERIODS_6 = 12'ha00;
  localparam logic [11:0] PERIODS_7 = 12'he00;

  typedef enum logic [1:0] {
    SEL_PINS, SEL_SHORTED, SEL_TEST_POS, SEL_TEST_NEG
  } input_sel_t;

  function automatic logic [11:0] periods_of(input logic [2:0] code);
    case (code)
      3'h0: periods_of = PERIODS_0;
      3'h1: periods_of = PERIODS_1;
      3'h2: periods_of = PERIODS_2;
      3'h3: periods_of = PERIODS_3;
      3'h4: periods_of = PERIODS_4;
      3'h5: periods_of = PERIODS_5;
      3'h6: periods_of = PERIODS_6;
      default: periods_of = PERIODS_7;
    endcase
  endfunction

  // {hit, slot}; hit needs an aligned word inside the bank
  function automatic logic [3:0] decode_addr(input logic [7:0] a);
    logic [5:0] idx;
    idx = a[7:2];
    decode_addr = {(a[1:0] == 2'h0) && (idx >= IDX_GLOBAL_CONFIG) &&
      (idx <= IDX_GAIN_LOW), 3'(idx - IDX_GLOBAL_CONFIG)};
  endfunction

endpackage

// ===== src/masked_word.sv
// one 16-bit setup register with a fixed writable mask
// assumes the write strobe is a single-cycle pulse on pclk
`timescale 1ns/1ns
module masked_word #(
  parameter logic [15:0] WMASK = 16'hffff,
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write side
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  // stored word
  output logic [15:0] value
);

  // reserved bits are masked on every write, so they never hold a one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= RESET_VAL & WMASK;
    end else if (wr_en) begin
      value <= wdata & WMASK;
    end
  end

endmodule

// ===== src/apb_access.sv
// apb slave timing: address decode, ready and error answer
// assumes a well-formed apb master on the same clock
`timescale 1ns/1ns
module apb_access
  import adc_cfg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  // apb answer
  output logic pready,
  output logic pslverr,
  // decoded access
  output logic setup,
  output logic hit,
  output logic [2:0] slot,
  output logic wr_en
);

  logic [3:0] dec;
  assign dec = decode_addr(paddr);
  assign hit = dec[3];
  assign slot = dec[2:0];
  assign setup = psel & ~penable;
  // writes land only at the completing edge of the access phase
  assign wr_en = psel & penable & pready & pwrite & hit;

  // ready rises for exactly the first access cycle: no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
    end
  end

endmodule

// ===== src/adc_setup_regs.sv
// setup register bank of a multichannel converter: current detect,
// global dc filter and channel 0 phase, input, offset and gain
// assumes an apb master on pclk; outputs feed the converter datapath
//
// Summary of operation
// - length code 0..7 selects 128 to 3584 conversion periods, reset 128
// - config bit 0 switches current-detect mode on, off after reset
// - threshold bits 23:8 held in full word at index 07h
// - threshold bits 7:0 in bits 15:8 at index 08h, joined
// - bits 3:0 at 08h hold global dc filter setting, 7:4 read zero
// - channel 0 bits 15:6 hold signed phase delay in modulator cycles
// - channel 0 bit 2 set bypasses its dc filter, clear follows global
// - channel 0 bits 1:0 pick pins, shorted, positive or negative test
// - channel 0 bits 5:3 are reserved and read zero
// - offset bits 23:8 held at index 0Ah, reset zero
// - offset bits 7:0 in bits 15:8 at 0Bh, low byte reads zero
// - gain is unsigned fraction 0.0 to below 2.0, bits 23:8 at 0Ch
// - gain words reset to 8000h and 0000h, unity gain
// - gain bits 7:0 in bits 15:8 at 0Dh, low byte reads zero
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
module adc_setup_regs
  import adc_cfg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // current detect
  output logic detect_mode_on,
  output logic [2:0] detect_measure_length,
  output logic [11:0] detect_measure_periods,
  output logic [23:0] detect_threshold,
  // dc filter
  output logic [3:0] global_dc_filter_setting,
  output logic chan0_dc_filter_bypass,
  output logic [3:0] chan0_dc_filter_setting,
  // channel 0 front end
  output logic [9:0] chan0_phase_delay,
  output input_sel_t chan0_input_select,
  // channel 0 calibration
  output logic [23:0] chan0_offset,
  output logic [23:0] chan0_gain
);

  //////////////////////////////////////////////////////////////////////
  // bus front end

  logic setup;
  logic hit;
  logic [2:0] slot;
  logic wr_en;

  apb_access u_access (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .setup(setup),
    .hit(hit),
    .slot(slot),
    .wr_en(wr_en)
  );

  //////////////////////////////////////////////////////////////////////
  // register words

  logic [15:0] word [NUM_REGS];

  // one masked word per slot; masks keep reserved bits at zero
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_word
      masked_word #(
        .WMASK(REG_MASK[gi]),
        .RESET_VAL(REG_RESET[gi])
      ) u_word (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_en && (slot == 3'(gi))),
        .wdata(pwdata[15:0]),
        .value(word[gi])
      );
    end
  endgenerate

  // named views of each slot
  logic [15:0] cfg_word;
  logic [15:0] thr_high_word;
  logic [15:0] thr_low_word;
  logic [15:0] setup_word;
  logic [15:0] ofs_high_word;
  logic [15:0] ofs_low_word;
  logic [15:0] gain_high_word;
  logic [15:0] gain_low_word;
  assign cfg_word = word[0];
  assign thr_high_word = word[1];
  assign thr_low_word = word[2];
  assign setup_word = word[3];
  assign ofs_high_word = word[4];
  assign ofs_low_word = word[5];
  assign gain_high_word = word[6];
  assign gain_low_word = word[7];

  //////////////////////////////////////////////////////////////////////
  // read path

  // read data captured in the setup cycle, so it is ready with pready;
  // upper half of the bus always reads zero
  logic [31:0] next_prdata;
  assign next_prdata = (setup && hit && !pwrite) ?
    {16'h0000, word[slot]} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= next_prdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // field outputs, taken straight from the stored words

  assign detect_mode_on = cfg_word[MODE_BIT];
  assign detect_measure_length = cfg_word[LEN_MSB:LEN_LSB];
  // halves joined so the detector sees one 24-bit signed value
  assign detect_threshold = {thr_high_word,
    thr_low_word[15:LOWER_LSB]};
  assign global_dc_filter_setting = thr_low_word[DCF_MSB:0];
  assign chan0_phase_delay = setup_word[15:PHASE_LSB];
  assign chan0_dc_filter_bypass = setup_word[BYPASS_BIT];
  assign chan0_input_select = input_sel_t'(setup_word[SEL_MSB:0]);
  assign chan0_offset = {ofs_high_word,
    ofs_low_word[15:LOWER_LSB]};
  // unsigned q1.23: 800000h is a gain of exactly one
  assign chan0_gain = {gain_high_word,
    gain_low_word[15:LOWER_LSB]};

  //////////////////////////////////////////////////////////////////////
  // derived outputs, one register stage behind the words

  // period count is decoded here once so the detector needs no table;
  // it trails the length field by one cycle, harmless for a setting
  logic [11:0] next_periods;
  logic [3:0] next_chan0_dcf;
  assign next_periods = periods_of(cfg_word[LEN_MSB:LEN_LSB]);
  // bypass forces the channel filter setting to zero, others follow
  assign next_chan0_dcf = setup_word[BYPASS_BIT] ?
    4'h0 : thr_low_word[DCF_MSB:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_measure_periods <= PERIODS_0;
      chan0_dc_filter_setting <= 4'h0;
    end else begin
      detect_measure_periods <= next_periods;
      chan0_dc_filter_setting <= next_chan0_dcf;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // a completed write to a given slot
  sequence wr_to(logic [2:0] s);
    psel && penable && pready && pwrite && hit && slot == s;
  endsequence

  // a read taken in setup and answered in the access cycle
  sequence rd_setup;
    psel && !penable && !pwrite && hit;
  endsequence

  periods_track_a: assert property (
    ##1 detect_measure_periods ==
      periods_of($past(cfg_word[LEN_MSB:LEN_LSB])))
    else $error("measure periods do not follow length code");

  mode_write_a: assert property (
    wr_to(3'h0) |=> detect_mode_on == $past(pwdata[MODE_BIT]))
    else $error("detect mode bit not taken from write");

  threshold_join_a: assert property (
    wr_to(3'h1) |=> detect_threshold[23:8] == $past(pwdata[15:0]))
    else $error("threshold upper word not stored");

  threshold_low_a: assert property (
    wr_to(3'h2) |=> detect_threshold[7:0] == $past(pwdata[15:8])
      && global_dc_filter_setting == $past(pwdata[3:0]))
    else $error("threshold lower byte or filter setting lost");

  reserved_zero_a: assert property (
    thr_low_word[7:4] == 4'h0 && cfg_word[15:4] == 12'h000)
    else $error("reserved bits of threshold or config set");

  phase_write_a: assert property (
    wr_to(3'h3) |=> chan0_phase_delay == $past(pwdata[15:6])
      && chan0_input_select == input_sel_t'($past(pwdata[1:0])))
    else $error("phase delay or input select not stored");

  bypass_gate_a: assert property (
    chan0_dc_filter_bypass ##1 !$past(wr_en) |->
      chan0_dc_filter_setting == 4'h0)
    else $error("bypassed channel filter not zero");

  follow_global_a: assert property (
    !chan0_dc_filter_bypass ##1 !$past(wr_en) |->
      chan0_dc_filter_setting == global_dc_filter_setting)
    else $error("channel filter does not follow global setting");

  setup_reserved_a: assert property (
    setup_word[5:3] == 3'h0)
    else $error("reserved bits of channel setup set");

  offset_write_a: assert property (
    wr_to(3'h4) ##1 (!wr_en) [*2] |->
      chan0_offset[23:8] == $past(pwdata[15:0], 2))
    else $error("offset upper word not held");

  low_bytes_a: assert property (
    ofs_low_word[7:0] == 8'h00 && gain_low_word[7:0] == 8'h00)
    else $error("reserved low byte of calibration word set");

  gain_write_a: assert property (
    wr_to(3'h6) |=> chan0_gain[23:8] == $past(pwdata[15:0]))
    else $error("gain upper word not stored");

  gain_lower_a: assert property (
    wr_to(3'h7) |=> chan0_gain[7:0] == $past(pwdata[15:8]))
    else $error("gain lower byte not stored");

  read_answer_a: assert property (
    rd_setup |=> pready && !pslverr && prdata[31:16] == 16'h0000
      && prdata[15:0] == $past(word[slot]))
    else $error("read answer wrong or late");

  unmapped_err_a: assert property (
    (psel && !penable && !hit) |=> pready && pslverr
      && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  single_ready_a: assert property (
    pready |=> !pready)
    else $error("ready stands longer than one cycle");

  // length code comes from bits 3:1 of the completing write
  length_write_a: assert property (
    wr_to(3'h0) |=> detect_measure_length == $past(pwdata[LEN_MSB:LEN_LSB]))
    else $error("measure length not taken from write");

  // lower offset byte lives in the upper half of its word
  offset_low_a: assert property (
    wr_to(3'h5) |=> chan0_offset[7:0] == $past(pwdata[15:8]))
    else $error("offset lower byte not stored");

  // bypass bit is taken from bit 2 of the channel setup write
  bypass_write_a: assert property (
    wr_to(3'h3) |=> chan0_dc_filter_bypass == $past(pwdata[BYPASS_BIT]))
    else $error("channel filter bypass not taken from write");

  // writes are answered at once, with zero read data
  write_answer_a: assert property (
    (psel && !penable && pwrite && hit) |=> pready && !pslverr
      && prdata == 32'h0000_0000)
    else $error("write answer wrong or late");

  // ready only ever follows a setup cycle
  ready_source_a: assert property (
    !(psel && !penable) |=> !pready)
    else $error("ready without a preceding setup cycle");

  // an error answer never stands without ready
  error_with_ready_a: assert property (
    pslverr |-> pready)
    else $error("error answer without ready");

  // each write lands in its own slot alone; every other word holds
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_hold
      word_hold_a: assert property (
        !(wr_en && slot == 3'(gi)) |=> $stable(word[gi]))
        else $error("register word changed without its own write");
    end
  endgenerate

  // slots written since reset; unwritten ones must show reset values
  logic [NUM_REGS-1:0] written;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      written <= '0;
    end else if (wr_en) begin
      written[slot] <= 1'b1;
    end
  end

  // checks every unwritten slot against its own reset constant, not only the gain
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_fresh
      word_reset_a: assert property (
        !written[gi] |-> word[gi] == REG_RESET[gi])
        else $error("unwritten register word left its reset value");
    end
  endgenerate

  // detect mode stays off and the length at 128 until configured
  mode_reset_a: assert property (
    !written[0] |-> !detect_mode_on && detect_measure_periods == PERIODS_0)
    else $error("detect mode or length not at reset state");

  // gain starts at unity after reset
  logic seen_gain_write;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_gain_write <= 1'b0;
    end else if (wr_en && (slot == 3'h6 || slot == 3'h7)) begin
      seen_gain_write <= 1'b1;
    end
  end

  gain_reset_a: assert property (
    !seen_gain_write |-> chan0_gain == 24'h80_0000)
    else $error("gain not at unity before any write");

endmodule

// ===== test/tb.sv
// self-checking bench for the converter setup register bank over apb
// assumes adc_cfg_pkg and the design files are compiled first
`timescale 1ns/1ns
module tb;
  import adc_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // clock, reset and apb wires
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // converter side outputs
  logic detect_mode_on;
  logic [2:0] detect_measure_length;
  logic [11:0] detect_measure_periods;
  logic [23:0] detect_threshold;
  logic [3:0] global_dc_filter_setting;
  logic chan0_dc_filter_bypass;
  logic [3:0] chan0_dc_filter_setting;
  logic [9:0] chan0_phase_delay;
  input_sel_t chan0_input_select;
  logic [23:0] chan0_offset;
  logic [23:0] chan0_gain;
  int n_fail;
  int checks_done;
  logic [31:0] rdat;
  logic rerr;
  // expected tables, index 06h first
  logic [15:0] rst_val [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h8000, 16'h0000};
  logic [15:0] wmask [8] = '{16'h000f, 16'hffff, 16'hff0f, 16'hffc7,
    16'hffff, 16'hff00, 16'hffff, 16'hff00};
  logic [11:0] periods [8] = '{12'h080, 12'h100, 12'h200, 12'h300,
    12'h500, 12'h700, 12'ha00, 12'he00};

  adc_setup_regs dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .detect_mode_on(detect_mode_on),
    .detect_measure_length(detect_measure_length),
    .detect_measure_periods(detect_measure_periods),
    .detect_threshold(detect_threshold),
    .global_dc_filter_setting(global_dc_filter_setting),
    .chan0_dc_filter_bypass(chan0_dc_filter_bypass),
    .chan0_dc_filter_setting(chan0_dc_filter_setting),
    .chan0_phase_delay(chan0_phase_delay),
    .chan0_input_select(chan0_input_select),
    .chan0_offset(chan0_offset), .chan0_gain(chan0_gain)
  );

  // free-running 8 ns clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // verdict and comparison
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; the wait for pready is bounded so a hang ends the run
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("ERROR pready expected 1 seen %b", pready);
      end_of_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    apb(1'b1, {idx, 2'b00}, {16'h0000, d}, rdat, rerr);
    chk("write slverr", {31'h0000_0000, rerr}, 32'h0000_0000);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [15:0] d);
    apb(1'b0, {idx, 2'b00}, 32'h0000_0000, rdat, rerr);
    chk("read slverr", {31'h0000_0000, rerr}, 32'h0000_0000);
    chk("read upper half", {16'h0000, rdat[31:16]}, 32'h0000_0000);
    d = rdat[15:0];
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      rd(IDX_GLOBAL_CONFIG + 6'(i), v);
      chk("reset word", {16'h0000, v}, {16'h0000, rst_val[i]});
    end
    chk("periods", {20'h0_0000, detect_measure_periods}, 32'h0000_0080);
    chk("mode on", {31'h0000_0000, detect_mode_on}, 32'h0000_0000);
    chk("dc setting", {28'h000_0000, global_dc_filter_setting}, 32'h0000_0000);
    chk("offset", {8'h00, chan0_offset}, 32'h0000_0000);
    chk("gain", {8'h00, chan0_gain}, 32'h0080_0000);
    $display("test reset done");
  endtask

  // ones into every word, reserved bits must stay zero
  task automatic t_masks();
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      wr(IDX_GLOBAL_CONFIG + 6'(i), 16'hffff);
      rd(IDX_GLOBAL_CONFIG + 6'(i), v);
      chk("masked word", {16'h0000, v}, {16'h0000, wmask[i]});
      wr(IDX_GLOBAL_CONFIG + 6'(i), 16'h0000);
      rd(IDX_GLOBAL_CONFIG + 6'(i), v);
      chk("cleared word", {16'h0000, v}, 32'h0000_0000);
    end
    $display("test masks done");
  endtask

  // every length code, mode bit toggling with it
  task automatic t_length();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(IDX_GLOBAL_CONFIG, {12'h000, c, c[0]});
      repeat (2) @(posedge pclk);
      chk("length", {29'h0000_0000, detect_measure_length}, {29'h0000_0000, c});
      chk("periods", {20'h0_0000, detect_measure_periods}, {20'h0_0000, periods[i]});
      chk("mode on", {31'h0000_0000, detect_mode_on}, {31'h0000_0000, c[0]});
    end
    $display("test length done");
  endtask

  // 24-bit values joined from two words, threshold low and gain high halves then updated alone
  task automatic t_join();
    wr(IDX_THRESHOLD_HIGH, 16'h8123);
    wr(IDX_THRESHOLD_LOW, 16'h45a9);
    wr(IDX_OFFSET_HIGH, 16'hfedc);
    wr(IDX_OFFSET_LOW, 16'hba77);
    wr(IDX_GAIN_HIGH, 16'h7fff);
    wr(IDX_GAIN_LOW, 16'hff11);
    repeat (2) @(posedge pclk);
    chk("threshold", {8'h00, detect_threshold}, 32'h0081_2345);
    chk("dc setting", {28'h000_0000, global_dc_filter_setting}, 32'h0000_0009);
    chk("offset", {8'h00, chan0_offset}, 32'h00fe_dcba);
    chk("gain", {8'h00, chan0_gain}, 32'h007f_ffff);
    wr(IDX_THRESHOLD_LOW, 16'h0000);
    repeat (2) @(posedge pclk);
    chk("threshold low", {8'h00, detect_threshold}, 32'h0081_2300);
    wr(IDX_THRESHOLD_LOW, 16'h0009);
    wr(IDX_GAIN_HIGH, 16'hffff);
    repeat (2) @(posedge pclk);
    chk("gain top", {8'h00, chan0_gain}, 32'h00ff_ffff);
    $display("test join done");
  endtask

  // every input selection, bypass on and off against global setting 9
  task automatic t_chan0();
    logic [9:0] ph;
    logic [1:0] s;
    logic [15:0] v;
    logic [3:0] exp_dcf;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      ph = 10'h201 + 10'(i * 85);
      wr(IDX_CHAN0_SETUP, {ph, 3'b111, s[0], s});
      repeat (2) @(posedge pclk);
      chk("input select", {30'h0000_0000, chan0_input_select}, {30'h0000_0000, s});
      chk("phase", {22'h00_0000, chan0_phase_delay}, {22'h00_0000, ph});
      chk("bypass", {31'h0000_0000, chan0_dc_filter_bypass}, {31'h0000_0000, s[0]});
      exp_dcf = s[0] ? 4'h0 : 4'h9;
      chk("chan0 dc", {28'h000_0000, chan0_dc_filter_setting}, {28'h000_0000, exp_dcf});
      rd(IDX_CHAN0_SETUP, v);
      chk("setup word", {16'h0000, v}, {16'h0000, ph, 3'b000, s[0], s});
    end
    $display("test chan0 done");
  endtask

  // unmapped and misaligned accesses answer with an error and change nothing
  task automatic t_refuse();
    logic [15:0] v;
    apb(1'b1, 8'h14, 32'h0000_ffff, rdat, rerr);
    chk("unmapped write err", {31'h0000_0000, rerr}, 32'h0000_0001);
    apb(1'b0, 8'h38, 32'h0000_0000, rdat, rerr);
    chk("unmapped read err", {31'h0000_0000, rerr}, 32'h0000_0001);
    chk("unmapped data", rdat, 32'h0000_0000);
    apb(1'b1, 8'h31, 32'h0000_1234, rdat, rerr);
    chk("misaligned err", {31'h0000_0000, rerr}, 32'h0000_0001);
    rd(IDX_GAIN_HIGH, v);
    chk("gain kept", {16'h0000, v}, 32'h0000_ffff);
    $display("test refuse done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_fail = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_masks();
    t_length();
    t_join();
    t_chan0();
    t_refuse();
    end_of_test();
  end
endmodule
